// [acs_map.svh]
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ----------------------------------------------------------------------
// clock and conversion timing
// ----------------------------------------------------------------------
`define ACS_CLK_FREQ_MHZ 40
`define ACS_CONV_TIME_NS 1000
// least time, so round up to whole cycles, never below one
`define ACS_CONV_CYC_RAW ((`ACS_CONV_TIME_NS * `ACS_CLK_FREQ_MHZ + 999) / 1000)
`define ACS_CONV_CYC ((`ACS_CONV_CYC_RAW < 1) ? 1 : `ACS_CONV_CYC_RAW)

// ----------------------------------------------------------------------
// control field encodings
// ----------------------------------------------------------------------
`define ACS_MODE_ONESHOT 1'h0
`define ACS_MODE_SCAN 1'h1
`define ACS_ACLK_SAME_AS_DIGITAL 1'h1
`define ACS_GO_WRITE_VALUE 1'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ACS_RST_FLAG 1'h0
`define ACS_RST_STATUS 1'h0

`endif

// [acs_pkg.sv]
package acs_pkg;

	// ------------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_NORMAL,
		ACS_INJECT
	} acs_state_t;

	// control mode of the main configuration register
	typedef logic acs_mode_t;

endpackage : acs_pkg

// [acs_xtrig_if.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// trigger link between cross trigger unit and converter
// ----------------------------------------------------------------------
interface acs_xtrig_if #(
	parameter int CHW = 3
);
	logic req;
	logic [CHW-1:0] chan;
	logic ack;
	logic acceptEn;

	modport dev (
		input req,
		input chan,
		output ack,
		output acceptEn
	);

	modport xtu (
		output req,
		output chan,
		input ack,
		input acceptEn
	);
endinterface : acs_xtrig_if

// [acs_cross_trigger_unit.sv]
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_cross_trigger_unit #(
	parameter int NT = 4,
	parameter int CHW = 3
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	acs_xtrig_if.xtu xt,
	input wire logic [NT-1:0] triggerChannelOn,
	input wire logic [NT-1:0][CHW-1:0] triggerChannelSel,
	output logic trigPending,
	output logic orderViolation
);
	import acs_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [$clog2(NT+1)-1:0] ptr;
		logic req;
		logic [CHW-1:0] chan;
		logic violation;
	} acs_xtu_state_t;

	acs_xtu_state_t r;
	acs_xtu_state_t next_r;

	// ------------------------------------------------------------------
	// round robin issue, one request outstanding at a time
	// ------------------------------------------------------------------
	always_comb begin
		int k;
		logic found;
		k = 0;
		found = 1'b0;
		next_r = r;
		// a channel on while the converter refuses triggers breaks bring-up order
		next_r.violation = (|triggerChannelOn) & ~xt.acceptEn;
		if (r.req) begin
			// hold the request until taken, so only one reaches the converter
			if (xt.ack) begin
				next_r.req = 1'b0;
				next_r.ptr = (int'(r.ptr) + 1 >= NT) ? '0 : r.ptr + 1'b1;
			end
		end else begin
			// every enabled channel keeps asking, turn after turn
			for (int j = 0; j < NT; j++) begin
				k = (int'(r.ptr) + j) % NT;
				if (!found && triggerChannelOn[k]) begin
					found = 1'b1;
					next_r.req = 1'b1;
					next_r.chan = triggerChannelSel[k];
					next_r.ptr = ($clog2(NT+1))'(k);
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign xt.req = r.req;
	assign xt.chan = r.chan;
	assign trigPending = r.req;
	assign orderViolation = r.violation;

endmodule : acs_cross_trigger_unit

// [acs_adc_sequencer.sv]
`timescale 1ns/1ps
`include "acs_map.svh"

// Summary of operation
// - software enables trigger acceptance before trigger channels
// - software disables trigger channels before clearing acceptance
// - enabled trigger channels keep requesting continuously
// - one-shot mode takes chain from channel select
// - go starts chain in ascending channel order
// - status go bit high during normal chain
// - software starts chain only when status idle
// - cancel sets injected done flag, self clears
// - software never aborts before a conversion starts
// - toggling acceptance enable restores trigger service
// - analog clock stops in power-down or idle
// - clock select one keeps analog clock running
// - scan cancel clears start, restart after done
// - trigger unit presents one trigger at once

module acs_adc_sequencer #(
	parameter int NCH = 8,
	parameter int CHW = 3
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	acs_xtrig_if.dev xt,
	input wire logic xtrigAcceptEn,
	input wire acs_pkg::acs_mode_t convMode,
	input wire logic scanStart,
	input wire logic normalSeqGo,
	input wire logic abortConv,
	input wire logic cancelSequence,
	input wire logic [NCH-1:0] normalChannelSelect0,
	input wire logic powerDown,
	input wire logic analogClkSel,
	input wire logic clrNormalSeqDone,
	input wire logic clrInjectedSeqDone,
	output logic normalSeqGoStatus,
	output logic cancelSequencePending,
	output logic normalSeqDoneFlag,
	output logic injectedSeqDoneFlag,
	output logic convValid,
	output logic convInjected,
	output logic [CHW-1:0] convChannel,
	output logic analogClkEn,
	output logic busy
);
	import acs_pkg::*;

	localparam logic [15:0] CONV_LAST = 16'(`ACS_CONV_CYC - 1);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		acs_state_t state;
		logic [CHW-1:0] chIdx;
		logic [CHW-1:0] resumeIdx;
		logic [CHW-1:0] injChan;
		logic [NCH-1:0] mask;
		logic [15:0] cnt;
		logic normalActive;
		logic cancelBit;
		logic nDone;
		logic jDone;
		logic ack;
		logic acceptEn;
		logic clkEn;
		logic cValid;
		logic cInj;
		logic [CHW-1:0] cChan;
		logic bsy;
	} acs_dev_state_t;

	acs_dev_state_t r;
	acs_dev_state_t next_r;

	// ------------------------------------------------------------------
	// lowest enabled channel at or above a start index
	// ------------------------------------------------------------------
	function automatic logic [CHW:0] acs_find(input logic [NCH-1:0] m, input int from);
		logic [CHW:0] res;
		res = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (m[i] && i >= from) begin
				res = {1'b1, CHW'(i)};
			end
		end
		return res;
	endfunction : acs_find

	// ------------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------------
	always_comb begin
		logic take;
		logic convDone;
		logic [CHW:0] hit;
		logic [CHW:0] first;
		take = 1'b0;
		convDone = 1'b0;
		hit = '0;
		first = acs_find(normalChannelSelect0, 0);
		next_r = r;
		next_r.ack = 1'b0;
		next_r.cValid = 1'b0;
		next_r.cInj = 1'b0;
		// clears first, so an event in the same cycle wins below
		if (clrNormalSeqDone) begin
			next_r.nDone = 1'b0;
		end
		if (clrInjectedSeqDone) begin
			next_r.jDone = 1'b0;
		end
		// acceptance follows the enable; no latched blocking state exists
		next_r.acceptEn = xtrigAcceptEn;
		// one request at a time, taken once, never while an injection runs
		take = r.acceptEn & xt.req & ~r.ack & (r.state != ACS_INJECT) & ~r.cancelBit;
		convDone = abortConv | (r.cnt == CONV_LAST);
		case (r.state)
			ACS_IDLE: begin
				if (take) begin
					next_r.state = ACS_INJECT;
					next_r.injChan = xt.chan;
					next_r.cnt = '0;
					next_r.ack = 1'b1;
				end else if (normalSeqGo == `ACS_GO_WRITE_VALUE) begin
					// chain channels come straight from select register 0
					next_r.mask = normalChannelSelect0;
					if (first[CHW]) begin
						next_r.state = ACS_NORMAL;
						next_r.normalActive = 1'b1;
						next_r.chIdx = first[CHW-1:0];
						next_r.cnt = '0;
					end else begin
						// empty chain ends at once
						next_r.nDone = 1'b1;
					end
				end
			end
			ACS_NORMAL: begin
				if (take) begin
					// the running normal channel is aborted and restored later
					next_r.resumeIdx = r.chIdx;
					next_r.state = ACS_INJECT;
					next_r.injChan = xt.chan;
					next_r.cnt = '0;
					next_r.ack = 1'b1;
				end else if (convDone) begin
					next_r.cValid = ~abortConv;
					next_r.cChan = r.chIdx;
					hit = acs_find(r.mask, int'(r.chIdx) + 1);
					next_r.cnt = '0;
					if (hit[CHW]) begin
						next_r.chIdx = hit[CHW-1:0];
					end else begin
						next_r.nDone = 1'b1;
						// scan repeats from the lowest channel while start holds
						if (convMode == `ACS_MODE_SCAN && scanStart && first[CHW]) begin
							next_r.mask = normalChannelSelect0;
							next_r.chIdx = first[CHW-1:0];
						end else begin
							next_r.state = ACS_IDLE;
							next_r.normalActive = 1'b0;
						end
					end
				end else begin
					next_r.cnt = r.cnt + 16'h0001;
				end
			end
			ACS_INJECT: begin
				if (convDone) begin
					next_r.cValid = ~abortConv;
					next_r.cInj = 1'b1;
					next_r.cChan = r.injChan;
					next_r.jDone = 1'b1;
					next_r.cnt = '0;
					if (r.normalActive) begin
						next_r.state = ACS_NORMAL;
						next_r.chIdx = r.resumeIdx;
					end else begin
						next_r.state = ACS_IDLE;
					end
				end else begin
					next_r.cnt = r.cnt + 16'h0001;
				end
			end
			default: begin
				next_r.state = ACS_IDLE;
				next_r.normalActive = 1'b0;
			end
		endcase
		// cancel ends everything, even from idle, so nothing stays blocked
		if (r.cancelBit) begin
			next_r.state = ACS_IDLE;
			next_r.normalActive = 1'b0;
			next_r.cnt = '0;
			next_r.cValid = 1'b0;
			next_r.jDone = 1'b1;
			next_r.cancelBit = 1'b0;
		end
		// a fresh cancel request wins over the self clear
		if (cancelSequence) begin
			next_r.cancelBit = 1'b1;
		end
		// analog clock always runs when select is one, else only outside power-down and idle
		next_r.clkEn = analogClkSel == `ACS_ACLK_SAME_AS_DIGITAL ? 1'b1 :
			(~powerDown & (next_r.state != ACS_IDLE));
		// busy is registered so the output needs no gate after the flops
		next_r.bsy = next_r.normalActive | (next_r.state == ACS_INJECT);
	end

	// go requests while a chain runs are dropped to keep channel order
	// (software is expected to poll the status bit first)

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
			r.state <= ACS_IDLE;
			r.nDone <= `ACS_RST_FLAG;
			r.jDone <= `ACS_RST_FLAG;
			r.normalActive <= `ACS_RST_STATUS;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign xt.ack = r.ack;
	assign xt.acceptEn = r.acceptEn;
	assign normalSeqGoStatus = r.normalActive;
	assign cancelSequencePending = r.cancelBit;
	assign normalSeqDoneFlag = r.nDone;
	assign injectedSeqDoneFlag = r.jDone;
	assign convValid = r.cValid;
	assign convInjected = r.cInj;
	assign convChannel = r.cChan;
	assign analogClkEn = r.clkEn;
	// chain active or injection running, registered from the next state so in step with the state register
	assign busy = r.bsy;

endmodule : acs_adc_sequencer

// [acs_link_checker.sv]
`timescale 1ns/1ps

module acs_link_checker #(
	parameter int CHW = 3
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic req,
	input wire logic [CHW-1:0] chan,
	input wire logic ack,
	input wire logic acceptEn
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------------
	// trigger link
	// ------------------------------------------------------------------
	a_ack_has_cause: assert property (ack |-> $past(req) && $past(acceptEn) && !$past(ack))
		else $error("ack without a taken request");
	a_no_ack_disabled: assert property (!acceptEn |=> !ack)
		else $error("ack while acceptance is off");
	a_service_bound: assert property (req && acceptEn && !ack |-> ##[1:60] (ack || !acceptEn))
		else $error("request not served in time");
	a_req_held: assert property (req && !ack |=> req)
		else $error("request dropped before ack");
	a_chan_stable: assert property (req && !ack |=> $stable(chan))
		else $error("channel changed while requesting");
	a_req_drop: assert property (ack |=> !req)
		else $error("request kept after ack");
	a_ack_single: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	// one trigger at a time: at least 8 cycles without ack lie between two acks
	a_trig_spacing: assert property (ack |=> !ack [*8])
		else $error("acks too close together");

	c_ack: cover property (ack);
	c_wait_off: cover property (req && !acceptEn);
	c_accept_fall: cover property ($fell(acceptEn));
endmodule : acs_link_checker

// [adc_conversion_sequencer_tb.sv]
`timescale 1ns/1ps
`include "acs_map.svh"

module adc_conversion_sequencer_tb;
	import acs_pkg::*;
	logic clk_sys, rst_b, xtrigAcceptEn, scanStart, normalSeqGo, abortConv, cancelSequence;
	logic powerDown, analogClkSel, clrNormalSeqDone, clrInjectedSeqDone;
	acs_mode_t convMode;
	logic [7:0] normalChannelSelect0;
	logic [3:0] triggerChannelOn;
	logic [3:0][2:0] triggerChannelSel;
	logic trigPending, orderViolation, normalSeqGoStatus, cancelSequencePending;
	logic normalSeqDoneFlag, injectedSeqDoneFlag, convValid, convInjected, analogClkEn, busy;
	logic [2:0] convChannel;
	int miscompares = 0;
	int n_tests = 0;

	// ------------------------------------------------------------------
	// both ends joined by the link
	// ------------------------------------------------------------------
	acs_xtrig_if acs_xtrig_if_inst ();
	acs_adc_sequencer acs_adc_sequencer_inst (.xt(acs_xtrig_if_inst), .*);
	acs_cross_trigger_unit acs_cross_trigger_unit_inst (.xt(acs_xtrig_if_inst), .*);
	acs_link_checker acs_link_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.req(acs_xtrig_if_inst.req), .chan(acs_xtrig_if_inst.chan),
		.ack(acs_xtrig_if_inst.ack), .acceptEn(acs_xtrig_if_inst.acceptEn));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// inputs move 2 ns after the edge, clear of sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : cyc

	// bounded wait for one result, then check kind and channel
	task automatic conv(input logic [2:0] ch, input logic inj);
		int k;
		k = 0;
		while (convValid !== 1'b1 && k < 200) begin
			cyc(1);
			k++;
		end
		chk({3'h0, convValid, convInjected, convChannel}, {3'h0, 1'b1, inj, ch});
		cyc(1);
	endtask : conv

	task automatic go(input logic [7:0] mask);
		normalChannelSelect0 = mask;
		normalSeqGo = 1'b1;
		cyc(1);
		normalSeqGo = 1'b0;
	endtask : go

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_chain;
		convMode = `ACS_MODE_ONESHOT;
		go(8'h05);
		chk({7'h00, normalSeqGoStatus}, 8'h01);
		conv(3'h0, 1'b0);
		conv(3'h2, 1'b0);
		chk({6'h00, normalSeqGoStatus, normalSeqDoneFlag}, 8'h01);
		chk({7'h00, analogClkEn}, 8'h00);
		clrNormalSeqDone = 1'b1;
		cyc(1);
		clrNormalSeqDone = 1'b0;
		chk({7'h00, normalSeqDoneFlag}, 8'h00);
		// abort only once the first channel runs; the chain moves on
		go(8'h03);
		cyc(5);
		abortConv = 1'b1;
		cyc(1);
		abortConv = 1'b0;
		conv(3'h1, 1'b0);
		chk({6'h00, normalSeqGoStatus, normalSeqDoneFlag}, 8'h01);
	endtask : t_chain

	task automatic t_scan;
		convMode = `ACS_MODE_SCAN;
		scanStart = 1'b1;
		go(8'h07);
		conv(3'h0, 1'b0);
		powerDown = 1'b1;
		cyc(1);
		chk({7'h00, analogClkEn}, 8'h00);
		analogClkSel = `ACS_ACLK_SAME_AS_DIGITAL;
		cyc(1);
		chk({7'h00, analogClkEn}, 8'h01);
		powerDown = 1'b0;
		analogClkSel = 1'b0;
		conv(3'h1, 1'b0);
		conv(3'h2, 1'b0);
		conv(3'h0, 1'b0);
		// cancel and stop repeating together
		cancelSequence = 1'b1;
		scanStart = 1'b0;
		cyc(1);
		cancelSequence = 1'b0;
		chk({7'h00, cancelSequencePending}, 8'h01);
		cyc(1);
		chk({5'h00, cancelSequencePending, normalSeqGoStatus, injectedSeqDoneFlag}, 8'h01);
		clrInjectedSeqDone = 1'b1;
		cyc(1);
		clrInjectedSeqDone = 1'b0;
	endtask : t_scan

	task automatic t_trig;
		xtrigAcceptEn = 1'b1;
		cyc(2);
		triggerChannelSel[0] = 3'h5;
		triggerChannelOn = 4'h1;
		conv(3'h5, 1'b1);
		conv(3'h5, 1'b1);
		triggerChannelOn = 4'h0;
		cyc(100);
		chk({7'h00, orderViolation}, 8'h00);
		xtrigAcceptEn = 1'b0;
		cyc(2);
	endtask : t_trig

	task automatic t_block;
		clrInjectedSeqDone = 1'b1;
		cyc(1);
		clrInjectedSeqDone = 1'b0;
		triggerChannelOn = 4'h1;
		cyc(60);
		chk({7'h00, injectedSeqDoneFlag}, 8'h00);
		chk({7'h00, trigPending}, 8'h01);
		chk({7'h00, orderViolation}, 8'h01);
		xtrigAcceptEn = 1'b1;
		conv(3'h5, 1'b1);
		triggerChannelOn = 4'h0;
		cyc(100);
		xtrigAcceptEn = 1'b0;
	endtask : t_block

	// trigger lands on a running normal channel, which restarts after it
	task automatic t_preempt;
		xtrigAcceptEn = 1'b1;
		triggerChannelSel[0] = 3'h4;
		cyc(2);
		go(8'h02);
		cyc(5);
		triggerChannelOn = 4'h1;
		cyc(2);
		// off again before the unit can ask a second time
		triggerChannelOn = 4'h0;
		chk({6'h00, busy, normalSeqGoStatus}, 8'h03);
		conv(3'h4, 1'b1);
		conv(3'h1, 1'b0);
		chk({6'h00, busy, normalSeqGoStatus}, 8'h00);
		xtrigAcceptEn = 1'b0;
	endtask : t_preempt

	task automatic conclude;
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		{xtrigAcceptEn, scanStart, normalSeqGo, abortConv, cancelSequence} = '0;
		{powerDown, analogClkSel, clrNormalSeqDone, clrInjectedSeqDone, convMode} = '0;
		normalChannelSelect0 = '0;
		triggerChannelOn = '0;
		triggerChannelSel = '0;
		rst_b = 1'b0;
		cyc(12);
		rst_b = 1'b1;
		cyc(2);
		t_chain();
		t_scan();
		t_trig();
		t_block();
		t_preempt();
		conclude();
	end

	// whole run needs under 1500 cycles; allow 5000
	initial begin
		#125000;
		miscompares++;
		conclude();
	end
endmodule : adc_conversion_sequencer_tb
